// ==== hdl/capture_reload_timer.sv ====
// 16-bit capture and auto-reload timer with baud rate generation
`timescale 1ns/1ns
`include "timer_two_defs.svh"
module capture_reload_timer #(
  parameter int WIDTH = 16
) (
  input wire logic clk_in,
  input wire logic reset_in,
  input wire logic [7:0] addr_in,
  input wire logic [7:0] write_data_in,
  input wire logic write_in,
  input wire logic read_in,
  output logic [7:0] read_data_out,
  input wire logic external_count_pin_in,
  input wire logic external_trigger_pin_in,
  input wire logic other_timer_overflow_in,
  output logic interrupt_out,
  output logic converter_start_out,
  output logic receive_shift_clock_out,
  output logic transmit_shift_clock_out
);

  // ----------------------------------------------------------------------
  // state
  // ----------------------------------------------------------------------
  logic [7:0] control_reg;
  logic prescale_select_reg;
  logic [WIDTH-1:0] count_reg;
  logic [WIDTH-1:0] count_next;
  logic [WIDTH-1:0] reload_reg;
  logic [WIDTH-1:0] reload_next;
  logic overflow_flag_next;
  logic external_flag_next;
  timer_two_pkg::timer_mode_e mode;
  logic count_fall;
  logic trigger_fall;
  logic slow_tick;
  logic baud_tick;
  logic advance;
  logic pin_half_reg;
  logic overflow;
  logic trigger_hit;
  logic wr_control;
  logic wr_count_low;
  logic wr_count_high;
  logic wr_reload_low;
  logic wr_reload_high;

  // named control fields
  logic overflow_flag;
  logic external_event_flag;
  logic receive_clock_select;
  logic transmit_clock_select;
  logic external_trigger_enable;
  logic run_control;
  logic counter_external_select;
  logic capture_reload_select;

  assign overflow_flag = control_reg[`CTL_OVERFLOW_BIT];
  assign external_event_flag = control_reg[`CTL_EXTERNAL_BIT];
  assign receive_clock_select = control_reg[`CTL_RX_CLOCK_BIT];
  assign transmit_clock_select = control_reg[`CTL_TX_CLOCK_BIT];
  assign external_trigger_enable = control_reg[`CTL_EXT_ENABLE_BIT];
  assign run_control = control_reg[`CTL_RUN_BIT];
  assign counter_external_select = control_reg[`CTL_COUNTER_SEL_BIT];
  assign capture_reload_select = control_reg[`CTL_CAPTURE_SEL_BIT];

  // ----------------------------------------------------------------------
  // helpers
  // ----------------------------------------------------------------------

  // write strobe decode for one register offset
  function automatic logic hit(input logic [7:0] a, input logic [7:0] off);
    hit = (a == off);
  endfunction : hit

  // replace one byte of a 16-bit word
  function automatic logic [15:0] put_byte(input logic [15:0] word,
                                           input logic high,
                                           input logic [7:0] data);
    put_byte = high ? {data, word[7:0]} : {word[15:8], data};
  endfunction : put_byte

  // ----------------------------------------------------------------------
  // pins and timebases
  // ----------------------------------------------------------------------
  pin_falling_edge count_pin_sync (
    .clk_in(clk_in),
    .reset_in(reset_in),
    .pin_in(external_count_pin_in),
    .fall_out(count_fall)
  );

  pin_falling_edge trigger_pin_sync (
    .clk_in(clk_in),
    .reset_in(reset_in),
    .pin_in(external_trigger_pin_in),
    .fall_out(trigger_fall)
  );

  tick_divider #(
    .DIVIDE(`SLOW_DIVIDE)
  ) slow_div (
    .clk_in(clk_in),
    .reset_in(reset_in),
    .tick_out(slow_tick)
  );

  tick_divider #(
    .DIVIDE(`BAUD_DIVIDE)
  ) baud_div (
    .clk_in(clk_in),
    .reset_in(reset_in),
    .tick_out(baud_tick)
  );

  // ----------------------------------------------------------------------
  // mode decode and counting
  // ----------------------------------------------------------------------

  // mode from run, clock selects and capture select
  always_comb begin
    if (!run_control) begin
      mode = timer_two_pkg::MODE_OFF;
    end else if (receive_clock_select | transmit_clock_select) begin
      mode = timer_two_pkg::MODE_BAUD;
    end else if (capture_reload_select) begin
      mode = timer_two_pkg::MODE_CAPTURE;
    end else begin
      mode = timer_two_pkg::MODE_RELOAD;
    end
  end

  // choose the increment source
  always_comb begin
    if (counter_external_select) begin
      // baud mode from the pin: one step per two falls
      advance = count_fall &
        (pin_half_reg | (mode != timer_two_pkg::MODE_BAUD));
    end else if (mode == timer_two_pkg::MODE_BAUD) begin
      advance = baud_tick;
    end else if (prescale_select_reg) begin
      advance = 1'b1;
    end else begin
      advance = slow_tick;
    end
    advance = advance & run_control;
  end

  // pin fall halver, cleared outside baud mode so phase starts fresh
  always_ff @(posedge clk_in or posedge reset_in) begin
    if (reset_in) begin
      pin_half_reg <= 1'b0;
    end else if (mode != timer_two_pkg::MODE_BAUD) begin
      pin_half_reg <= 1'b0;
    end else if (counter_external_select && count_fall) begin
      pin_half_reg <= ~pin_half_reg;
    end
  end

  // overflow only on a real step out of all ones
  assign overflow = advance & (count_reg == {WIDTH{1'b1}});
  // trigger falls count only with the enable set
  assign trigger_hit = trigger_fall & external_trigger_enable;

  // bus write decode
  assign wr_control = write_in & hit(addr_in, `TIMER_TWO_CONTROL_ADDR);
  assign wr_count_low = write_in & hit(addr_in, `COUNT_LOW_BYTE_ADDR);
  assign wr_count_high = write_in & hit(addr_in, `COUNT_HIGH_BYTE_ADDR);
  assign wr_reload_low = write_in & hit(addr_in, `CAPTURE_RELOAD_LOW_ADDR);
  assign wr_reload_high = write_in & hit(addr_in, `CAPTURE_RELOAD_HIGH_ADDR);

  // next counter value
  always_comb begin
    count_next = count_reg;
    if (mode == timer_two_pkg::MODE_CAPTURE) begin
      if (advance) begin
        count_next = count_reg + 16'h0001;
      end
    end else if (mode == timer_two_pkg::MODE_RELOAD) begin
      if (trigger_hit) begin
        count_next = reload_reg;
      end else if (overflow) begin
        count_next = reload_reg;
      end else if (advance) begin
        count_next = count_reg + 16'h0001;
      end
    end else if (mode == timer_two_pkg::MODE_BAUD) begin
      if (overflow) begin
        count_next = reload_reg;
      end else if (advance) begin
        count_next = count_reg + 16'h0001;
      end
    end
    if (wr_count_low) begin
      count_next = put_byte(count_next, 1'b0, write_data_in);
    end
    if (wr_count_high) begin
      count_next = put_byte(count_next, 1'b1, write_data_in);
    end
  end

  // counter register
  always_ff @(posedge clk_in or posedge reset_in) begin
    if (reset_in) begin
      count_reg <= {WIDTH{1'b0}};
    end else begin
      count_reg <= count_next;
    end
  end

  // capture or software load of the capture/reload pair
  always_comb begin
    reload_next = reload_reg;
    if (mode == timer_two_pkg::MODE_CAPTURE && trigger_hit) begin
      reload_next = count_reg;
    end
    if (wr_reload_low) begin
      reload_next = put_byte(reload_next, 1'b0, write_data_in);
    end
    if (wr_reload_high) begin
      reload_next = put_byte(reload_next, 1'b1, write_data_in);
    end
  end

  always_ff @(posedge clk_in or posedge reset_in) begin
    if (reset_in) begin
      reload_reg <= {WIDTH{1'b0}};
    end else begin
      reload_reg <= reload_next;
    end
  end

  // ----------------------------------------------------------------------
  // control register and flags
  // ----------------------------------------------------------------------

  // flags: software write first, hardware set wins
  always_comb begin
    overflow_flag_next = overflow_flag;
    external_flag_next = external_event_flag;
    if (wr_control) begin
      overflow_flag_next = write_data_in[`CTL_OVERFLOW_BIT];
      external_flag_next = write_data_in[`CTL_EXTERNAL_BIT];
    end
    if (overflow && (mode == timer_two_pkg::MODE_CAPTURE ||
                     mode == timer_two_pkg::MODE_RELOAD)) begin
      overflow_flag_next = 1'b1;
    end
    if (trigger_hit && mode != timer_two_pkg::MODE_OFF) begin
      external_flag_next = 1'b1;
    end
  end

  always_ff @(posedge clk_in or posedge reset_in) begin
    if (reset_in) begin
      control_reg <= `CONTROL_RESET;
    end else begin
      control_reg[`CTL_OVERFLOW_BIT] <= overflow_flag_next;
      control_reg[`CTL_EXTERNAL_BIT] <= external_flag_next;
      if (wr_control) begin
        control_reg[5:0] <= write_data_in[5:0];
      end
    end
  end

  // prescale select in the clock prescale control register
  always_ff @(posedge clk_in or posedge reset_in) begin
    if (reset_in) begin
      prescale_select_reg <= 1'b0;
    end else if (write_in && hit(addr_in, `CLOCK_PRESCALE_CONTROL_ADDR)) begin
      prescale_select_reg <= write_data_in[`PRESCALE_SELECT_BIT];
    end
  end

  // ----------------------------------------------------------------------
  // register read port, data one cycle after the strobe
  // ----------------------------------------------------------------------
  always_ff @(posedge clk_in or posedge reset_in) begin
    if (reset_in) begin
      read_data_out <= `BYTE_RESET;
    end else if (read_in) begin
      unique case (addr_in)
        `TIMER_TWO_CONTROL_ADDR: read_data_out <= control_reg;
        `CAPTURE_RELOAD_LOW_ADDR: read_data_out <= reload_reg[7:0];
        `CAPTURE_RELOAD_HIGH_ADDR: read_data_out <= reload_reg[15:8];
        `COUNT_LOW_BYTE_ADDR: read_data_out <= count_reg[7:0];
        `COUNT_HIGH_BYTE_ADDR: read_data_out <= count_reg[15:8];
        `CLOCK_PRESCALE_CONTROL_ADDR: begin
          read_data_out <= {2'b00, prescale_select_reg, 5'b00000};
        end
        default: read_data_out <= `BYTE_RESET;
      endcase
    end else begin
      read_data_out <= `BYTE_RESET;
    end
  end

  // ----------------------------------------------------------------------
  // outputs to interrupt, converter and serial port
  // ----------------------------------------------------------------------
  always_ff @(posedge clk_in or posedge reset_in) begin
    if (reset_in) begin
      interrupt_out <= 1'b0;
      converter_start_out <= 1'b0;
      receive_shift_clock_out <= 1'b0;
      transmit_shift_clock_out <= 1'b0;
    end else begin
      interrupt_out <= overflow_flag_next | external_flag_next;
      converter_start_out <= overflow;
      receive_shift_clock_out <= receive_clock_select ?
        (overflow & (mode == timer_two_pkg::MODE_BAUD)) :
        other_timer_overflow_in;
      transmit_shift_clock_out <= transmit_clock_select ?
        (overflow & (mode == timer_two_pkg::MODE_BAUD)) :
        other_timer_overflow_in;
    end
  end

endmodule : capture_reload_timer

// ==== hdl/timer_two_defs.svh ====
// register offsets, field positions and timing counts of the timer
`ifndef TIMER_TWO_DEFS_SVH
`define TIMER_TWO_DEFS_SVH

// ----------------------------------------------------------------------
// register offsets
// ----------------------------------------------------------------------
`define TIMER_TWO_CONTROL_ADDR 8'hc8
`define CAPTURE_RELOAD_LOW_ADDR 8'hca
`define CAPTURE_RELOAD_HIGH_ADDR 8'hcb
`define COUNT_LOW_BYTE_ADDR 8'hcc
`define COUNT_HIGH_BYTE_ADDR 8'hcd
`define CLOCK_PRESCALE_CONTROL_ADDR 8'h8e

// ----------------------------------------------------------------------
// control fields and reset values
// ----------------------------------------------------------------------
`define CTL_OVERFLOW_BIT 7
`define CTL_EXTERNAL_BIT 6
`define CTL_RX_CLOCK_BIT 5
`define CTL_TX_CLOCK_BIT 4
`define CTL_EXT_ENABLE_BIT 3
`define CTL_RUN_BIT 2
`define CTL_COUNTER_SEL_BIT 1
`define CTL_CAPTURE_SEL_BIT 0
`define PRESCALE_SELECT_BIT 5
`define PRESCALE_CTL_MASK 8'h38
`define CONTROL_RESET 8'h00
`define BYTE_RESET 8'h00

// ----------------------------------------------------------------------
// timing counts
// ----------------------------------------------------------------------
`define SLOW_DIVIDE 12
`define BAUD_DIVIDE 2

`endif

// ==== hdl/timer_two_pkg.sv ====
// types shared by the timer files
package timer_two_pkg;

  // operating mode decoded from the control register
  typedef enum logic [1:0] {
    MODE_OFF,
    MODE_CAPTURE,
    MODE_RELOAD,
    MODE_BAUD
  } timer_mode_e;

endpackage : timer_two_pkg

// ==== hdl/pin_falling_edge.sv ====
// two-stage synchroniser with falling edge detector for one pin
`timescale 1ns/1ns
module pin_falling_edge (
  input wire logic clk_in,
  input wire logic reset_in,
  input wire logic pin_in,
  output logic fall_out
);

  logic meta_reg;
  logic sync_reg;
  logic last_reg;

  // synchronise, then keep one older sample
  always_ff @(posedge clk_in or posedge reset_in) begin
    if (reset_in) begin
      meta_reg <= 1'b1;
      sync_reg <= 1'b1;
      last_reg <= 1'b1;
    end else begin
      meta_reg <= pin_in;
      sync_reg <= meta_reg;
      last_reg <= sync_reg;
    end
  end

  // high sample then low sample
  assign fall_out = last_reg & ~sync_reg;

endmodule : pin_falling_edge

// ==== hdl/tick_divider.sv ====
// free running divider giving a one-cycle tick every DIVIDE clocks
`timescale 1ns/1ns
module tick_divider #(
  parameter int DIVIDE = 12
) (
  input wire logic clk_in,
  input wire logic reset_in,
  output logic tick_out
);

  logic [7:0] count_reg;

  // count up and wrap
  always_ff @(posedge clk_in or posedge reset_in) begin
    if (reset_in) begin
      count_reg <= 8'h00;
    end else if (count_reg == 8'(DIVIDE - 1)) begin
      count_reg <= 8'h00;
    end else begin
      count_reg <= count_reg + 8'h01;
    end
  end

  assign tick_out = (count_reg == 8'(DIVIDE - 1));

endmodule : tick_divider

// ==== verification/timer_checker.sv ====
// timing checker on the ports of the capture and reload timer
`timescale 1ns/1ns
module timer_checker #(
  parameter int WIDTH = 16
) (
  input wire logic clk_in,
  input wire logic reset_in,
  input wire logic [7:0] addr_in,
  input wire logic [7:0] write_data_in,
  input wire logic write_in,
  input wire logic read_in,
  input wire logic [7:0] read_data_out,
  input wire logic other_timer_overflow_in,
  input wire logic interrupt_out,
  input wire logic converter_start_out,
  input wire logic receive_shift_clock_out,
  input wire logic transmit_shift_clock_out
);
  logic [5:0] sw_reg;
  logic mapped;
  logic baud_quiet;
  default clocking @(posedge clk_in); endclocking
  default disable iff (reset_in);
  // control bits only software writes
  always_ff @(posedge clk_in or posedge reset_in) begin
    if (reset_in) sw_reg <= 6'h00;
    else if (write_in && addr_in == 8'hc8) sw_reg <= write_data_in[5:0];
  end
  // decoded helpers
  assign mapped = addr_in inside {8'hc8, 8'hca, 8'hcb, 8'hcc, 8'hcd, 8'h8e};
  assign baud_quiet = (sw_reg[5] | sw_reg[4]) && !sw_reg[3] && !write_in;
  sequence ctl_read;
    read_in && addr_in == 8'hc8;
  endsequence
  a_read_idle_zero: assert property (!$past(read_in) |-> read_data_out == 8'h00)
    else $error("read data not zero outside read cycle");
  a_unmapped_read: assert property (read_in && !mapped |=> read_data_out == 8'h00)
    else $error("unmapped read not zero");
  a_prescale_bits: assert property (read_in && addr_in == 8'h8e |=>
    (read_data_out & 8'hdf) == 8'h00) else $error("prescale spare bits set");
  a_ctl_readback: assert property (ctl_read |=> read_data_out[5:0] == $past(sw_reg))
    else $error("control readback wrong");
  a_flag_sw_clear: assert property ($fell(interrupt_out) |->
    $past(write_in) && $past(addr_in) == 8'hc8) else $error("flag self cleared");
  a_baud_no_flag: assert property ($past(baud_quiet) |-> !$rose(interrupt_out))
    else $error("baud overflow raised request");
  a_rx_other_path: assert property (!$past(sw_reg[5]) |->
    receive_shift_clock_out == $past(other_timer_overflow_in))
    else $error("receive clock not other timer");
  a_tx_other_path: assert property (!$past(sw_reg[4]) |->
    transmit_shift_clock_out == $past(other_timer_overflow_in))
    else $error("transmit clock not other timer");
  a_off_no_start: assert property (!$past(sw_reg[2]) && !$past(sw_reg[2], 2)
    |-> !converter_start_out) else $error("start pulse while stopped");
endmodule : timer_checker
bind capture_reload_timer timer_checker #(.WIDTH(WIDTH)) checker_i (
  .clk_in(clk_in), .reset_in(reset_in), .addr_in(addr_in),
  .write_data_in(write_data_in), .write_in(write_in), .read_in(read_in),
  .read_data_out(read_data_out),
  .other_timer_overflow_in(other_timer_overflow_in),
  .interrupt_out(interrupt_out), .converter_start_out(converter_start_out),
  .receive_shift_clock_out(receive_shift_clock_out),
  .transmit_shift_clock_out(transmit_shift_clock_out));

// ==== verification/uart_clock_model.sv ====
// serial port clock side: counts shift pulses and divides by 16
`timescale 1ns/1ns
module uart_clock_model (
  input wire logic clk_in,
  input wire logic reset_in,
  input wire logic rx_clock_in,
  input wire logic tx_clock_in,
  output int rx_pulses_out,
  output int tx_pulses_out,
  output logic [3:0] rx_phase_out
);
  // pulse counters and bit phase of the receiver
  always @(posedge clk_in or posedge reset_in) begin
    if (reset_in) begin
      rx_pulses_out <= 0;
      tx_pulses_out <= 0;
      rx_phase_out <= 4'h0;
    end else begin
      rx_pulses_out <= rx_pulses_out + int'(rx_clock_in);
      tx_pulses_out <= tx_pulses_out + int'(tx_clock_in);
      rx_phase_out <= rx_phase_out + {3'h0, rx_clock_in};
    end
  end
endmodule : uart_clock_model

// ==== verification/capture_reload_timer_test.sv ====
// self-checking bench for the capture and reload timer
`timescale 1ns/1ns
module capture_reload_timer_test;
  logic clk_in = 1'b0, reset_in = 1'b1, wr_s = 1'b0, rd_s = 1'b0;
  logic cpin = 1'b1, tpin = 1'b1, other = 1'b0, irq, conv, rxc, txc;
  logic [7:0] addr_in = 8'h00, wdata = 8'h00, rdata, m_ctl = 8'h00;
  logic [15:0] m_cnt = 16'h0000, m_rel = 16'h0000, v;
  logic [3:0] phase;
  int err_total = 0, n_checks = 0, cycles = 0, seed = 32'h84fc;
  int rxp, txp, m_baud = 0, ones = 0;
  int half = 0, m_ovf = 0, conv_n = 0;
  int lo_t[3] = '{9, 120, 59}, hi_t[3] = '{11, 124, 63};
  capture_reload_timer dut (.clk_in(clk_in), .reset_in(reset_in),
    .addr_in(addr_in), .write_data_in(wdata), .write_in(wr_s),
    .read_in(rd_s), .read_data_out(rdata),
    .external_count_pin_in(cpin), .external_trigger_pin_in(tpin),
    .other_timer_overflow_in(other), .interrupt_out(irq),
    .converter_start_out(conv), .receive_shift_clock_out(rxc),
    .transmit_shift_clock_out(txc));
  uart_clock_model far (.clk_in(clk_in), .reset_in(reset_in),
    .rx_clock_in(rxc), .tx_clock_in(txc), .rx_pulses_out(rxp),
    .tx_pulses_out(txp), .rx_phase_out(phase));
  // clock
  initial forever #5 clk_in = ~clk_in;
  // converter start pulses seen
  always @(posedge clk_in) begin
    if (conv === 1'b1) conv_n <= conv_n + 1;
  end
  // hang limit
  always @(posedge clk_in) begin
    cycles <= cycles + 1;
    if (cycles == 40000) begin
      err_total = err_total + 1;
      complete_run();
    end
  end
  task automatic complete_run();
    $display("checks %0d mismatches %0d", n_checks, err_total);
    if (err_total == 0 && n_checks > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask : complete_run
  task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
    n_checks = n_checks + 1;
    if (seen !== exp) begin
      err_total = err_total + 1;
      $display("FAIL %0t seen %h expected %h", $time, seen, exp);
    end
  endtask : chk
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge clk_in);
    addr_in <= a;
    wdata <= d;
    wr_s <= 1'b1;
    @(posedge clk_in);
    wr_s <= 1'b0;
  endtask : wr
  task automatic rd(input logic [7:0] a, output logic [7:0] d);
    @(posedge clk_in);
    addr_in <= a;
    rd_s <= 1'b1;
    @(posedge clk_in);
    rd_s <= 1'b0;
    #1 d = rdata;
  endtask : rd
  task automatic setc(input logic [7:0] c);
    wr(8'hc8, c);
    m_ctl = c;
    if (!(c[2] && (c[5] | c[4]))) half = 0;
  endtask : setc
  task automatic set16(input logic [7:0] a, input logic [15:0] c);
    wr(a, c[7:0]);
    wr(a + 8'h01, c[15:8]);
  endtask : set16
  task automatic check_state();
    logic [7:0] lo, hi;
    rd(8'hc8, lo);
    chk({8'h00, lo}, {8'h00, m_ctl});
    rd(8'hcc, lo);
    rd(8'hcd, hi);
    chk({hi, lo}, m_cnt);
    rd(8'hca, lo);
    rd(8'hcb, hi);
    chk({hi, lo}, m_rel);
    chk({15'h0, irq}, {15'h0, m_ctl[7] | m_ctl[6]});
  endtask : check_state
  // count pin falls, model advances per fall, per second fall in baud mode
  task automatic falls(input int n);
    repeat (n) begin
      cpin <= 1'b0;
      repeat (4) @(posedge clk_in);
      cpin <= 1'b1;
      repeat (4) @(posedge clk_in);
      if (m_ctl[2] && (m_ctl[5] | m_ctl[4])) half = half ^ 1;
      else half = 0;
      if (m_ctl[2] && half == 0 && m_cnt != 16'hffff) m_cnt = m_cnt + 16'h1;
      else if (m_ctl[2] && half == 0) begin
        m_cnt = (m_ctl[0] && !(m_ctl[5] | m_ctl[4])) ? 16'h0 : m_rel;
        m_ovf = m_ovf + 1;
        if (m_ctl[5] | m_ctl[4]) m_baud = m_baud + 1;
        else m_ctl[7] = 1'b1;
      end
    end
  endtask : falls
  // trigger pin fall
  task automatic trig();
    tpin <= 1'b0;
    repeat (4) @(posedge clk_in);
    tpin <= 1'b1;
    repeat (4) @(posedge clk_in);
    if (m_ctl[2] && m_ctl[3]) begin
      m_ctl[6] = 1'b1;
      if (!(m_ctl[5] | m_ctl[4]) && m_ctl[0]) m_rel = m_cnt;
      else if (!(m_ctl[5] | m_ctl[4])) m_cnt = m_rel;
    end
  endtask : trig
  // main sequence
  initial begin
    logic [7:0] b;
    repeat (10) @(posedge clk_in);
    reset_in <= 1'b0;
    check_state();
    rd(8'h00, b);
    chk({8'h00, b}, 16'h0000);
    wr(8'h8e, 8'hff);
    rd(8'h8e, b);
    chk({8'h00, b}, 16'h0020);
    setc(8'h07);
    falls(5);
    setc(8'h03);
    falls(2);
    check_state();
    set16(8'hcc, 16'hfffe);
    m_cnt = 16'hfffe;
    setc(8'h07);
    falls(3);
    trig();
    check_state();
    setc(8'h0f);
    trig();
    check_state();
    setc(8'h00);
    v = 16'($random(seed));
    set16(8'hca, v);
    m_rel = v;
    set16(8'hcc, 16'hfffe);
    m_cnt = 16'hfffe;
    setc(8'h06);
    falls(3);
    check_state();
    setc(8'h0e);
    falls(1);
    trig();
    check_state();
    setc(8'h00);
    set16(8'hcc, 16'hfff8);
    m_cnt = 16'hfff8;
    setc(8'h3f);
    falls(17);
    trig();
    check_state();
    chk(16'(rxp), 16'(m_baud));
    chk(16'(txp), 16'(m_baud));
    for (int i = 0; i < 3; i++) begin
      setc(8'h00);
      set16(8'hcc, 16'h0000);
      wr(8'h8e, i == 1 ? 8'h20 : 8'h00);
      setc(i == 2 ? 8'h34 : 8'h04);
      repeat (120) @(posedge clk_in);
      setc(8'h00);
      rd(8'hcc, b);
      chk(16'(int'(b) >= lo_t[i] && int'(b) <= hi_t[i]), 16'h0001);
    end
    for (int i = 0; i < 40; i++) begin
      @(posedge clk_in);
      b = 8'($random(seed));
      other <= b[0];
      ones = ones + int'(b[0]);
    end
    @(posedge clk_in);
    other <= 1'b0;
    repeat (3) @(posedge clk_in);
    chk(16'(rxp - m_baud), 16'(ones));
    chk(16'(txp - m_baud), 16'(ones));
    chk({12'h000, phase}, 16'((m_baud + ones) % 16));
    chk(16'(conv_n), 16'(m_ovf));
    complete_run();
  end
endmodule : capture_reload_timer_test
